// ### design/scirq_top.sv
`timescale 1ns/1ns
module scirq_top
    import scirq_pkg::*;
(
    // Clock and reset
    input  wire logic           i_core_clk,
    input  wire logic           i_rst,
    // Register bus
    input  wire scirq_axi_req_t i_axi,
    output scirq_axi_rsp_t      o_axi,
    // Card UART event pulses, one per flag position
    input  wire logic [7:0]     i_evt,
    // Interrupt request
    output logic                o_card_irq,
    output logic [7:0]          o_irq_pending,
    // Mode outputs to the card UART
    output logic                o_bank_select,
    output logic [2:0]          o_repeat_limit,
    // Alternate card clock source ticks
    input  wire logic           i_alt_clk_tick,
    // Port function of the shared pin
    input  wire logic           i_port_out,
    input  wire logic           i_port_oe,
    output logic                o_port_pin_in,
    // Shared pin
    input  wire logic           i_pin_in,
    output logic                o_pin_out,
    output logic                o_pin_oe
);

    // ------------------------------------------------------------------
    // Register state
    scirq_ier_t       ier_r;
    scirq_sel_t       sel_r;
    logic [7:0]       ident_r;
    logic [7:0]       ident_nxt;
    logic [7:0]       en_vec;
    logic [7:0]       gated;

    // Write channel
    scirq_wr_state_t  wr_state_r;
    logic             aw_held_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic             w_held_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic [1:0]       bresp_r;
    logic             aw_hs;
    logic             w_hs;
    logic             do_write;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic             wr_sel;
    logic             wr_irq;

    // Read channel
    scirq_rd_state_t  rd_state_r;
    logic [31:0]      rdata_r;
    logic [1:0]       rresp_r;
    logic             ar_hs;
    logic             rd_sel;
    logic             rd_irq;
    logic             rd_clear;
    logic [7:0]       rd_byte;

    // Alternate clock and pin
    logic             div_clk;
    logic             pin_sync1_r;
    logic             pin_sync2_r;

    // ------------------------------------------------------------------
    // Write address and data are taken in either order
    assign aw_hs = i_axi.awvalid && o_axi.awready;
    assign w_hs  = i_axi.wvalid && o_axi.wready;

    assign wr_addr = aw_held_r ? awaddr_r : i_axi.awaddr;
    assign wr_data = w_held_r ? wdata_r : i_axi.wdata;
    assign wr_strb = w_held_r ? wstrb_r : i_axi.wstrb;

    assign do_write = (wr_state_r == WR_IDLE)
                   && (aw_held_r || aw_hs)
                   && (w_held_r || w_hs);

    assign wr_sel = (wr_addr[AXI_AW-1:2] == SEL_IDX);
    assign wr_irq = (wr_addr[AXI_AW-1:2] == IRQ_IDX);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end else if (aw_hs) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= i_axi.awaddr;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end else if (w_hs) begin
            w_held_r <= 1'b1;
            wdata_r  <= i_axi.wdata;
            wstrb_r  <= i_axi.wstrb;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_state_r <= WR_IDLE;
            bresp_r    <= RESP_OKAY;
        end else begin
            unique case (wr_state_r)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state_r <= WR_RESP;
                        bresp_r    <= (wr_sel || wr_irq) ? RESP_OKAY
                                                         : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (i_axi.bready) begin
                        wr_state_r <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Selection register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_r <= scirq_sel_t'(SEL_RST);
        end else if (do_write && wr_sel && wr_strb[0]) begin
            sel_r <= scirq_sel_t'(wr_data[7:0] & SEL_MASK);
        end
    end

    // Enable register, reached only while bank select is one
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ier_r <= scirq_ier_t'(IER_RST);
        end else if (do_write && wr_irq && wr_strb[0]
                     && sel_r.bank_select) begin
            ier_r <= scirq_ier_t'(wr_data[7:0] & IER_MASK);
        end
    end

    // ------------------------------------------------------------------
    // Read channel answers one cycle after the address is taken
    assign ar_hs  = i_axi.arvalid && o_axi.arready;
    assign rd_sel = (i_axi.araddr[AXI_AW-1:2] == SEL_IDX);
    assign rd_irq = (i_axi.araddr[AXI_AW-1:2] == IRQ_IDX);

    // Flag read clears them
    assign rd_clear = ar_hs && rd_irq && !sel_r.bank_select;

    always_comb begin
        rd_byte = 8'h00;
        if (rd_sel) begin
            rd_byte = sel_r & SEL_MASK;
        end else if (rd_irq && sel_r.bank_select) begin
            rd_byte = ier_r & IER_MASK;
        end else if (rd_irq) begin
            rd_byte = ident_r;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_state_r <= RD_IDLE;
            rdata_r    <= '0;
            rresp_r    <= RESP_OKAY;
        end else begin
            unique case (rd_state_r)
                RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state_r <= RD_RESP;
                        rdata_r    <= {24'h000000, rd_byte};
                        rresp_r    <= (rd_sel || rd_irq) ? RESP_OKAY
                                                         : RESP_SLVERR;
                    end
                end
                RD_RESP: begin
                    if (i_axi.rready) begin
                        rd_state_r <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        o_axi         = '0;
        o_axi.awready = (wr_state_r == WR_IDLE) && !aw_held_r;
        o_axi.wready  = (wr_state_r == WR_IDLE) && !w_held_r;
        o_axi.bvalid  = (wr_state_r == WR_RESP);
        o_axi.bresp   = bresp_r;
        o_axi.arready = (rd_state_r == RD_IDLE);
        o_axi.rvalid  = (rd_state_r == RD_RESP);
        o_axi.rdata   = rdata_r;
        o_axi.rresp   = rresp_r;
    end

    // ------------------------------------------------------------------
    // Identification flags: an event in the clearing cycle survives
    assign ident_nxt = (ident_r & ~(rd_clear ? IER_MASK : 8'h00))
                     | (i_evt & IER_MASK);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ident_r <= IDENT_RST;
        end else begin
            ident_r <= ident_nxt;
        end
    end

    // Enable vector in flag order
    assign en_vec[TBE_BIT] = ier_r.tx_buffer_empty_irq_en;
    assign en_vec[6]       = 1'b0;
    assign en_vec[CUR_BIT] = ier_r.card_current_err_irq_en;
    assign en_vec[VOL_BIT] = ier_r.card_voltage_err_irq_en;
    assign en_vec[WTO_BIT] = ier_r.wait_timeout_irq_en;
    assign en_vec[TXD_BIT] = ier_r.tx_done_irq_en;
    assign en_vec[RXD_BIT] = ier_r.rx_done_irq_en;
    assign en_vec[PAR_BIT] = ier_r.parity_err_irq_en;

    for (genvar i = 0; i < 8; i++) begin : g_gate
        assign gated[i] = ident_r[i] & en_vec[i];
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_pending <= 8'h00;
            o_card_irq    <= 1'b0;
        end else begin
            o_irq_pending <= gated;
            o_card_irq    <= |gated;
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_repeat_limit <= REPEAT_CLEAR;
        end else begin
            o_repeat_limit <= sel_r.repeat_count_select ? REPEAT_SET
                                                        : REPEAT_CLEAR;
        end
    end

    assign o_bank_select = sel_r.bank_select;

    // ------------------------------------------------------------------
    // Alternate card clock
    scirq_clk_div u_div (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_tick     (i_alt_clk_tick),
        .i_code     (sel_r.alt_clock_prescale),
        .o_tick     (),
        .o_clk      (div_clk)
    );

    // Pin carries the divided clock or the plain port function
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b0;
        end else if (sel_r.alt_clock_route_select) begin
            o_pin_out <= div_clk;
            o_pin_oe  <= 1'b1;
        end else begin
            o_pin_out <= i_port_out;
            o_pin_oe  <= i_port_oe;
        end
    end

    // Pin level back to the port, synchronised
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_sync1_r <= 1'b0;
            pin_sync2_r <= 1'b0;
        end else begin
            pin_sync1_r <= i_pin_in;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    assign o_port_pin_in = pin_sync2_r;

endmodule : scirq_top

// ### pkg/scirq_pkg.sv
package scirq_pkg;

    // Register indices as printed; byte address is four times the index
    localparam int          AXI_AW          = 12;
    localparam logic [9:0]  SEL_IDX         = 10'h0ab;
    localparam logic [9:0]  IRQ_IDX         = 10'h0ae;

    // Values after reset
    localparam logic [7:0]  SEL_RST         = 8'h08;
    localparam logic [7:0]  IER_RST         = 8'h00;
    localparam logic [7:0]  IDENT_RST       = 8'h00;

    // Implemented bits
    localparam logic [7:0]  IER_MASK        = 8'hbf;
    localparam logic [7:0]  SEL_MASK        = 8'h1f;

    // Flag positions, shared by enable and identification
    localparam int          TBE_BIT         = 7;
    localparam int          CUR_BIT         = 5;
    localparam int          VOL_BIT         = 4;
    localparam int          WTO_BIT         = 3;
    localparam int          TXD_BIT         = 2;
    localparam int          RXD_BIT         = 1;
    localparam int          PAR_BIT         = 0;

    // Repetitions before a parity error is reported
    localparam logic [2:0]  REPEAT_CLEAR    = 3'h5;
    localparam logic [2:0]  REPEAT_SET      = 3'h4;

    // Alternate clock divider
    localparam int          DIV_CNT_W       = 3;
    localparam logic [2:0]  DIV_CNT_RST     = 3'h0;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic tx_buffer_empty_irq_en;
        logic rsvd6;
        logic card_current_err_irq_en;
        logic card_voltage_err_irq_en;
        logic wait_timeout_irq_en;
        logic tx_done_irq_en;
        logic rx_done_irq_en;
        logic parity_err_irq_en;
    } scirq_ier_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       repeat_count_select;
        logic [1:0] alt_clock_prescale;
        logic       alt_clock_route_select;
        logic       bank_select;
    } scirq_sel_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic [2:0]        awprot;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic [2:0]        arprot;
        logic              rready;
    } scirq_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scirq_axi_rsp_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } scirq_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } scirq_rd_state_t;

endpackage : scirq_pkg

// ### design/scirq_clk_div.sv
`timescale 1ns/1ns
module scirq_clk_div
    import scirq_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // Source ticks and factor code
    input  wire logic       i_tick,
    input  wire logic [1:0] i_code,
    // Divided outputs
    output logic            o_tick,
    output logic            o_clk
);

    logic [DIV_CNT_W-1:0] cnt_r;
    logic [1:0]           code_r;
    logic [DIV_CNT_W-1:0] limit;
    logic                 hit;

    // Factor 1, 2, 4 or 8 for codes 0 to 3
    assign limit = DIV_CNT_W'((4'h1 << i_code) - 4'h1);
    assign hit   = i_tick && (cnt_r == limit);

    // A new code restarts the count so no stretched period appears
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= DIV_CNT_RST;
            code_r <= SEL_RST[3:2];
        end else begin
            code_r <= i_code;
            if (code_r != i_code) begin
                cnt_r <= DIV_CNT_RST;
            end else if (hit) begin
                cnt_r <= DIV_CNT_RST;
            end else if (i_tick) begin
                cnt_r <= cnt_r + DIV_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tick <= 1'b0;
            o_clk  <= 1'b0;
        end else begin
            o_tick <= hit && (code_r == i_code);
            if (hit && (code_r == i_code)) begin
                o_clk <= ~o_clk;
            end
        end
    end

endmodule : scirq_clk_div

// ### dv/scirq_props.sv
`timescale 1ns/1ns
module scirq_props
    import scirq_pkg::*;
(
    // Clock and reset
    input  wire logic           i_core_clk,
    input  wire logic           i_rst,
    // Register bus
    input  wire scirq_axi_req_t i_axi,
    input  wire scirq_axi_rsp_t o_axi,
    // Interrupt and mode outputs
    input  wire logic           o_card_irq,
    input  wire logic [7:0]     o_irq_pending,
    input  wire logic [2:0]     o_repeat_limit,
    // Shared pin
    input  wire logic           i_port_out,
    input  wire logic           i_port_oe,
    input  wire logic           i_pin_in,
    input  wire logic           o_pin_out,
    input  wire logic           o_pin_oe,
    input  wire logic           o_port_pin_in
);
    // Cycles since reset release, saturating
    logic [1:0] up_r;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_IRQ_ANY: assert property (o_card_irq == (|o_irq_pending))
        else $error("irq differs from pending");
    AST_RSVD_BIT: assert property (o_irq_pending[6] == 1'b0)
        else $error("pending bit 6 set");
    AST_REPEAT: assert property (o_repeat_limit == REPEAT_CLEAR ||
        o_repeat_limit == REPEAT_SET)
        else $error("bad repeat limit");
    AST_PIN_OE: assert property (up_r == 2'h3 && i_port_oe |=> o_pin_oe)
        else $error("pin enable dropped");
    AST_PIN_PORT: assert property (up_r == 2'h3 && !o_pin_oe |->
        o_pin_out == $past(i_port_out))
        else $error("pin not following port");
    AST_PIN_SYNC: assert property (up_r == 2'h3 |->
        o_port_pin_in == $past(i_pin_in, 2))
        else $error("pin input delay wrong");
    AST_WR_RESP: assert property (i_axi.awvalid && o_axi.awready &&
        i_axi.wvalid && o_axi.wready |=> o_axi.bvalid)
        else $error("write response late");
    AST_RD_RESP: assert property (i_axi.arvalid && o_axi.arready |=>
        o_axi.rvalid ##0 o_axi.rdata[31:8] == 24'h0)
        else $error("read response wrong");
    AST_RD_HOLD: assert property (o_axi.rvalid && !i_axi.rready |=>
        o_axi.rvalid && $stable(o_axi.rdata))
        else $error("read data not held");

    COV_IRQ: cover property (o_card_irq);
    COV_REP: cover property (o_repeat_limit == REPEAT_SET);
    COV_CLK: cover property (o_pin_oe && o_pin_out);
endmodule : scirq_props

bind scirq_top scirq_props chk_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
    .o_card_irq(o_card_irq), .o_irq_pending(o_irq_pending),
    .o_repeat_limit(o_repeat_limit), .i_port_out(i_port_out),
    .i_port_oe(i_port_oe), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_port_pin_in(o_port_pin_in)
);

// ### dv/smart_card_irq_enable_select_tb_top.sv
`timescale 1ns/1ns
module smart_card_irq_enable_select_tb_top;
    import scirq_pkg::*;
    localparam logic [11:0] A_SEL = 12'h2ac;
    localparam logic [11:0] A_SHR = 12'h2b8;
    logic           clk, rst, tick, pout, poe, pin;
    logic           irq, bank, po, poe_o, ppin, prev, x0, x1;
    scirq_axi_req_t rq;
    scirq_axi_rsp_t rs;
    logic [7:0]     evt, pend, e;
    logic [2:0]     rep;
    logic [1:0]     br;
    int             bad_count, total_checks, sel_m, ier_m, flg_m, cnt;

    scirq_top dut_u (
        .i_core_clk(clk), .i_rst(rst), .i_axi(rq), .o_axi(rs), .i_evt(evt),
        .o_card_irq(irq), .o_irq_pending(pend), .o_bank_select(bank),
        .o_repeat_limit(rep), .i_alt_clk_tick(tick), .i_port_out(pout),
        .i_port_oe(poe), .o_port_pin_in(ppin), .i_pin_in(pin),
        .o_pin_out(po), .o_pin_oe(poe_o)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Port function and pin input wander freely
    always @(posedge clk) begin
        {pout, poe, pin} <= 3'($urandom);
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int   n;
        logic pa, pw, ta, tw;
        n  = 0;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        rq.awvalid <= 1'b1;
        rq.wvalid  <= 1'b1;
        rq.bready  <= 1'b1;
        rq.awaddr  <= a;
        rq.wdata   <= {24'h0, d};
        // Each channel is released at the edge that takes it
        while ((pa || pw) && n < 99) begin
            @(negedge clk);
            ta = pa && rs.awready;
            tw = pw && rs.wready;
            @(posedge clk);
            if (ta) rq.awvalid <= 1'b0;
            if (tw) rq.wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            n++;
        end
        do @(negedge clk); while (!rs.bvalid && ++n < 99);
        r = rs.bresp;
        @(posedge clk);
        rq.bready <= 1'b0;
        if (n >= 99) begin
            bad_count++;
            $display("[ERR] %0t write timed out", $time);
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        rq.arvalid <= 1'b1;
        rq.rready  <= 1'b1;
        rq.araddr  <= a;
        do @(negedge clk); while (!rs.arready && ++n < 99);
        @(posedge clk);
        rq.arvalid <= 1'b0;
        do @(negedge clk); while (!rs.rvalid && ++n < 99);
        d = rs.rdata;
        r = rs.rresp;
        @(posedge clk);
        rq.rready <= 1'b0;
        if (n >= 99) begin
            bad_count++;
            $display("[ERR] %0t read timed out", $time);
        end
    endtask : rd

    task automatic mwr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        if (a == A_SEL) sel_m = d & 8'h1f;
        else if (a == A_SHR && sel_m[0]) ier_m = d & 8'hbf;
        chk(r, (a == A_SEL || a == A_SHR) ? RESP_OKAY : RESP_SLVERR);
    endtask : mwr

    task automatic mrd(input logic [11:0] a);
        logic [31:0] d;
        logic [1:0]  r;
        int          x;
        rd(a, d, r);
        x = a == A_SEL ? sel_m : a == A_SHR ? (sel_m[0] ? ier_m : flg_m) : 0;
        if (a == A_SHR && !sel_m[0]) flg_m = 0;
        chk(d, x);
        chk(r, (a == A_SEL || a == A_SHR) ? RESP_OKAY : RESP_SLVERR);
    endtask : mrd

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #(50 * 20000);
        bad_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'h1a4e283c));
        rst = 1'b1;
        rq = '0;
        rq.wstrb = 4'hf;
        evt = 8'h00;
        tick = 1'b1;
        {pout, poe, pin} = 3'h0;
        sel_m = 8'h08;
        ier_m = 0;
        flg_m = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        mrd(A_SEL);
        chk(rep, REPEAT_CLEAR);
        mwr(A_SEL, 8'hff);
        mrd(A_SEL);
        mwr(A_SEL, 8'h01);
        chk(bank, 1'b1);
        mrd(A_SHR);
        mwr(A_SHR, 8'hff);
        mrd(A_SHR);
        rq.wstrb <= 4'he;
        wr(A_SEL, 8'h00, br);
        rq.wstrb <= 4'hf;
        chk(br, RESP_OKAY);
        mrd(A_SEL);
        mrd(12'h100);
        mwr(12'h104, 8'h5a);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            e = 8'($urandom) | (8'h01 << k);
            mwr(A_SEL, 8'h01);
            mwr(A_SHR, 8'h01 << k);
            @(posedge clk);
            evt <= e;
            @(posedge clk);
            evt <= 8'h00;
            flg_m |= e & 8'hbf;
            @(posedge clk);
            @(negedge clk);
            chk(pend, flg_m & ier_m);
            chk(irq, |(flg_m & ier_m));
            mwr(A_SEL, 8'h00);
            mwr(A_SHR, 8'hff);
            mrd(A_SHR);
            mrd(A_SHR);
            chk(pend, 8'h00);
            chk(irq, 1'b0);
        end
        // An event held across the clearing read keeps its flag
        @(posedge clk);
        evt <= 8'h02;
        flg_m = 8'h02;
        mrd(A_SHR);
        evt <= 8'h00;
        flg_m = 8'h02;
        mrd(A_SHR);
        mrd(A_SHR);
        chk(bank, 1'b0);
        $display("test enables done");
        mwr(A_SEL, 8'h10);
        repeat (2) @(negedge clk);
        chk(rep, REPEAT_SET);
        for (int c = 0; c < 4; c++) begin
            mwr(A_SEL, 8'(c << 2) | 8'h02);
            repeat (20) @(negedge clk);
            cnt = 0;
            prev = po;
            repeat (64) begin
                @(negedge clk);
                cnt += int'(po && !prev);
                prev = po;
            end
            chk(cnt, 32 >> c);
            chk(poe_o, 1'b1);
        end
        mwr(A_SEL, 8'h00);
        @(negedge clk);
        x0 = pout;
        x1 = poe;
        @(negedge clk);
        chk({po, poe_o}, {x0, x1});
        $display("test alternate clock done");
        close_out();
    end
endmodule : smart_card_irq_enable_select_tb_top
